// ==== common/pscl_pkg.sv ====
// Constants and types for the strap configuration latch
package pscl_pkg;
  // Multilevel strap levels, first to fourth
  typedef enum logic [1:0] {
    LVL_FIRST = 2'h0,
    LVL_SECOND = 2'h1,
    LVL_THIRD = 2'h2,
    LVL_FOURTH = 2'h3
  } pscl_level_t;
  // MAC interface selections
  typedef enum logic [1:0] {
    MACIF_RGMII_BOTH = 2'h0,
    MACIF_RGMII_RXC = 2'h1,
    MACIF_MII = 2'h2,
    MACIF_RMII = 2'h3
  } pscl_macif_t;
  // Sensed-level comparator taps: above 0.1, 0.5, 0.9 of the pin supply
  localparam int SENSE_TAPS = 3;
  localparam int TAP_SECOND = 0;
  localparam int TAP_THIRD = 1;
  localparam int TAP_FOURTH = 2;
  localparam int PICK0_BIT = 0;
  localparam int PICK1_BIT = 1;
  // Internal RGMII clock delay in picoseconds
  localparam int RGMII_DELAY_PS = 2000;
  // Reference clock rates in MHz
  localparam int REFCLK_RMII_MHZ = 50;
  localparam int REFCLK_OTHER_MHZ = 25;
  // Reset values
  localparam logic [1:0] MACIF_RST = 2'h0;
  localparam logic [1:0] LEVEL_RST = 2'h0;
endpackage : pscl_pkg

// ==== design/pscl_strap_latch.sv ====
// Strap capture at reset release and MAC interface / power-down control
//
// Function
// - Every strap is sampled when reset is released and held as the power-on setting.
// - A multilevel strap resolves to one of four levels, first to fourth by sensed voltage.
// - Above 0.1 of supply gives level two, above 0.5 level three, above 0.9 level four.
// - A two-level strap resolves only to the lowest or highest level.
// - The MAC interface comes from two two-level select straps that default low.
// - Selects low-low RGMII both delays, low-high RGMII rx delay, high-low MII, high-high RMII.
// - RMII can only be chosen by straps and never by software.
// - RMII uses a 50 MHz reference clock while MII and RGMII use 25 MHz.
// - In managed use the device enters power-down after reset and is configured only there.
// - MII and RMII carry 10 and 100 Mbps only, RGMII also carries gigabit.
// - Unmanaged, the device runs from latched straps and brings up the link unless strapped or software-set to power down.
// - With a synchronous phase-fixed reference clock in MII the interface FIFO is bypassed.
`timescale 1ns/1ps
module pscl_strap_latch
  import pscl_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  // Thermometer comparator outputs per multilevel strap: bit i = above tap i
  input wire logic [pscl_pkg::SENSE_TAPS-1:0] speedStrapLoSense,
  input wire logic [pscl_pkg::SENSE_TAPS-1:0] speedStrapHiSense,
  input wire logic [pscl_pkg::SENSE_TAPS-1:0] pwrDnStrapSense,
  input wire logic macIfPick0,
  input wire logic macIfPick1,
  input wire logic managedMode,
  input wire logic clkInPhaseLocked,
  input wire logic swCfgValid,
  input wire logic [1:0] swMacIf,
  input wire logic swPowerDown,
  input wire logic swPowerDownSet,
  input wire logic linkCableDetect,
  output logic [1:0] speedLevelLo,
  output logic [1:0] speedLevelHi,
  output logic [1:0] pwrDnLevel,
  output logic [1:0] macIfSel,
  output logic rgmiiTxDelayEn,
  output logic rgmiiRxDelayEn,
  output logic refClk50Sel,
  output logic gigAllowed,
  output logic fifoBypass,
  output logic powerDown,
  output logic mgmtReady,
  output logic swCfgReject,
  output logic linkUpEnable
);
  import pscl_pkg::*;

  // Multilevel straps, one decode and latch slice each
  localparam int ML_STRAPS = 3;
  localparam int ML_LO = 0;
  localparam int ML_HI = 1;
  localparam int ML_PD = 2;

  // Reset phase: exactly one capture edge, then run until the next reset
  typedef enum logic [1:0] {
    PH_CAPTURE = 2'b01,
    PH_RUN = 2'b10
  } pscl_phase_t;

  // Highest tap crossed wins; a non-monotone comparator word still decodes sanely
  function automatic logic [1:0] decode_level(input logic [SENSE_TAPS-1:0] s);
    if (s[TAP_FOURTH]) begin
      decode_level = LVL_FOURTH;
    end else if (s[TAP_THIRD]) begin
      decode_level = LVL_THIRD;
    end else if (s[TAP_SECOND]) begin
      decode_level = LVL_SECOND;
    end else begin
      decode_level = LVL_FIRST;
    end
  endfunction : decode_level

  // Both RGMII flavours; shared by the delay and speed decodes
  function automatic logic is_rgmii(input logic [1:0] m);
    is_rgmii = (m == MACIF_RGMII_BOTH) | (m == MACIF_RGMII_RXC);
  endfunction : is_rgmii

  function automatic logic is_rmii(input logic [1:0] m);
    is_rmii = (m == MACIF_RMII);
  endfunction : is_rmii

  pscl_phase_t phase_r;
  pscl_phase_t phase_nxt;
  logic [1:0] macIfSel_r;
  logic [1:0] macIfSel_nxt;
  logic powerDown_r;
  logic powerDown_nxt;
  logic swCfgReject_r;
  logic swCfgReject_nxt;

  wire logic capture = (phase_r == PH_CAPTURE);
  wire logic running = (phase_r == PH_RUN);

  // Once running, only a reset returns to capture
  always_comb begin
    phase_nxt = phase_r;
    unique case (phase_r)
      PH_CAPTURE: begin
        phase_nxt = PH_RUN;
      end
      PH_RUN: begin
        phase_nxt = PH_RUN;
      end
      default: begin
        // A corrupted code recaptures rather than running on stale straps
        phase_nxt = PH_CAPTURE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_r <= PH_CAPTURE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // Latches close after the capture edge, so later traffic on shared pins is ignored
  genvar g;
  generate
    for (g = 0; g < ML_STRAPS; g++) begin : gen_ml
      wire logic [SENSE_TAPS-1:0] sense = (g == ML_LO) ? speedStrapLoSense :
                                          (g == ML_HI) ? speedStrapHiSense :
                                          pwrDnStrapSense;
      wire logic [1:0] levelNow = decode_level(sense);
      logic [1:0] level_r;
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          level_r <= LEVEL_RST;
        end else if (capture) begin
          level_r <= levelNow;
        end
      end
    end
  endgenerate

  // Two-level straps map to the lowest or highest level only
  wire logic [1:0] strapMacIf = {macIfPick0, macIfPick1};
  wire logic swWantsRmii = is_rmii(swMacIf);
  wire logic swCfgTry = swCfgValid & running;
  wire logic swCfgOk = swCfgTry & powerDown_r & managedMode & ~swWantsRmii;
  wire logic curRmii = is_rmii(macIfSel_r);
  // RMII needs the faster reference clock, which software cannot provide
  wire logic swCfgAccept = swCfgOk & ~curRmii;
  // Any strap level above the first asks for power-down
  wire logic strapPwrDn = (gen_ml[ML_PD].levelNow != LVL_FIRST);

  // Software may only move between non-RMII modes, and an RMII strap stays locked
  assign macIfSel_nxt = capture ? strapMacIf :
                        swCfgAccept ? swMacIf : macIfSel_r;

  // Managed parts come up powered down; set wins over a same-cycle clear
  assign powerDown_nxt = capture ? (managedMode | strapPwrDn) :
                         swPowerDownSet ? 1'b1 :
                         (managedMode && running) ? swPowerDown : powerDown_r;

  assign swCfgReject_nxt = swCfgTry & ~swCfgAccept;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      macIfSel_r <= MACIF_RST;
    end else begin
      macIfSel_r <= macIfSel_nxt;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      powerDown_r <= 1'b1;
    end else begin
      powerDown_r <= powerDown_nxt;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      swCfgReject_r <= 1'b0;
    end else begin
      swCfgReject_r <= swCfgReject_nxt;
    end
  end

  assign speedLevelLo = gen_ml[ML_LO].level_r;
  assign speedLevelHi = gen_ml[ML_HI].level_r;
  assign pwrDnLevel = gen_ml[ML_PD].level_r;
  assign macIfSel = macIfSel_r;
  assign powerDown = powerDown_r;
  assign swCfgReject = swCfgReject_r;

  // Interface side effects all follow the registered selection
  assign rgmiiTxDelayEn = (macIfSel_r == MACIF_RGMII_BOTH);
  assign rgmiiRxDelayEn = is_rgmii(macIfSel_r);
  assign refClk50Sel = curRmii;
  assign gigAllowed = is_rgmii(macIfSel_r);

  // Bypass only when the phase lock is real; a drifting clock would corrupt data
  assign fifoBypass = (macIfSel_r == MACIF_MII) & clkInPhaseLocked;

  // Management waits one edge so the RMII strap is already in force
  assign mgmtReady = running;

  // Unmanaged parts bring the link up from straps unless strapped or software-set to power down
  assign linkUpEnable = running & ~powerDown_r & linkCableDetect;
endmodule : pscl_strap_latch

// ==== test/pscl_checker.sv ====
// Port-level assertions for the strap configuration latch
`timescale 1ns/1ps
module pscl_checker
  import pscl_pkg::*;
(
  input wire logic clk, sys_rst, macIfPick0, macIfPick1, managedMode, clkInPhaseLocked,
  input wire logic swCfgValid, rgmiiTxDelayEn, refClk50Sel, gigAllowed, fifoBypass,
  input wire logic powerDown, mgmtReady, swCfgReject,
  input wire logic rgmiiRxDelayEn, linkUpEnable, linkCableDetect, swPowerDownSet,
  input wire logic [1:0] swMacIf, macIfSel, speedLevelLo, pwrDnLevel
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic take = swCfgValid && mgmtReady;
  AST_CAPTURE: assert property ($rose(mgmtReady) |->
    macIfSel == {$past(macIfPick0), $past(macIfPick1)}) else $error("strap capture wrong");
  AST_HOLD: assert property (mgmtReady && $past(mgmtReady) |->
    $stable(speedLevelLo) && $stable(pwrDnLevel)) else $error("latched level moved");
  AST_MANAGED_PD: assert property ($rose(mgmtReady) && $past(managedMode) |->
    powerDown) else $error("managed start not powered down");
  AST_REFUSE: assert property (take && (!powerDown || !managedMode ||
    swMacIf == MACIF_RMII) |=> swCfgReject && $stable(macIfSel)) else $error("bad write taken");
  AST_ACCEPT: assert property (take && powerDown && managedMode && swMacIf != MACIF_RMII &&
    macIfSel != MACIF_RMII |=> macIfSel == $past(swMacIf) && !swCfgReject)
    else $error("good write lost");
  AST_TX_DELAY: assert property (rgmiiTxDelayEn == (macIfSel == MACIF_RGMII_BOTH))
    else $error("tx delay decode wrong");
  AST_REFCLK: assert property (refClk50Sel == (macIfSel == MACIF_RMII))
    else $error("reference clock select wrong");
  AST_GIG: assert property (
    gigAllowed == (macIfSel inside {MACIF_RGMII_BOTH, MACIF_RGMII_RXC}))
    else $error("gigabit permission wrong");
  AST_RX_DELAY: assert property (
    rgmiiRxDelayEn == (macIfSel inside {MACIF_RGMII_BOTH, MACIF_RGMII_RXC}))
    else $error("rx delay decode wrong");
  AST_LINK: assert property (linkUpEnable == (mgmtReady && !powerDown && linkCableDetect))
    else $error("link enable wrong");
  AST_PD_SET: assert property (mgmtReady && swPowerDownSet |=> powerDown)
    else $error("power-down set lost");
  AST_FIFO: assert property (fifoBypass == (macIfSel == MACIF_MII && clkInPhaseLocked))
    else $error("fifo bypass wrong");
endmodule : pscl_checker
bind pscl_strap_latch pscl_checker chk (.*);

// ==== test/pscl_strap_model.sv ====
// Board strap resistors: sensed level to comparator thermometer
`timescale 1ns/1ps
module pscl_strap_model (
  input wire logic [1:0] lvLo, lvHi, lvPd,
  output logic [2:0] loSense, hiSense, pdSense
);
  // Level n trips the n lowest taps; the first level trips none
  assign loSense = (3'h1 << lvLo) - 3'h1;
  assign hiSense = (3'h1 << lvHi) - 3'h1;
  assign pdSense = (3'h1 << lvPd) - 3'h1;
endmodule : pscl_strap_model

// ==== test/tb_top.sv ====
// Self-checking bench for the strap configuration latch
`timescale 1ns/1ps
module tb_top;
  import pscl_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, macIfPick0 = 1'b0, macIfPick1 = 1'b0, managedMode = 1'b0;
  logic clkInPhaseLocked = 1'b1, swCfgValid = 1'b0, swPowerDown = 1'b1;
  logic swPowerDownSet = 1'b0, linkCableDetect = 1'b1;
  logic [1:0] swMacIf = 2'h0, lvLo = 2'h0, lvHi = 2'h0, lvPd = 2'h0;
  logic [2:0] speedStrapLoSense, speedStrapHiSense, pwrDnStrapSense;
  logic [1:0] speedLevelLo, speedLevelHi, pwrDnLevel, macIfSel;
  logic rgmiiTxDelayEn, rgmiiRxDelayEn, refClk50Sel, gigAllowed, fifoBypass;
  logic powerDown, mgmtReady, swCfgReject, linkUpEnable;
  int badCount = 0, checksDone = 0;
  pscl_strap_model strap (.lvLo(lvLo), .lvHi(lvHi), .lvPd(lvPd), .loSense(speedStrapLoSense),
    .hiSense(speedStrapHiSense), .pdSense(pwrDnStrapSense));
  pscl_strap_latch dut (.*);
  task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  // Straps change only while reset is held, as on a real board
  task automatic boot(input logic [1:0] lo, hi, pdl, input logic p0, p1, man);
    @(posedge clk);
    {sys_rst, lvLo, lvHi, lvPd} <= {1'b1, lo, hi, pdl};
    {macIfPick0, macIfPick1, managedMode} <= {p0, p1, man};
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : boot
  // Host write: one-cycle strobe, answer one cycle later
  task automatic wr(input logic [1:0] m, input logic rej);
    @(posedge clk);
    {swCfgValid, swMacIf} <= {1'b1, m};
    @(posedge clk);
    swCfgValid <= 1'b0;
    #1;
    chk("swCfgReject", {1'b0, rej}, {1'b0, swCfgReject});
  endtask : wr
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : endOfTest
  initial begin
    forever #2 clk = ~clk;
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      boot(i[1:0], 2'h3 - i[1:0], 2'h0, i[1], i[0], 1'b0);
      chk("macIfSel", i[1:0], macIfSel);
      chk("speedLevelLo", i[1:0], speedLevelLo);
      chk("speedLevelHi", 2'h3 - i[1:0], speedLevelHi);
      chk("refClk50Sel", {1'b0, i == 3}, {1'b0, refClk50Sel});
      chk("gigAllowed", {1'b0, i < 2}, {1'b0, gigAllowed});
      chk("powerDown", 2'h0, {1'b0, powerDown});
      chk("rgmiiTxDelayEn", {1'b0, i == 0}, {1'b0, rgmiiTxDelayEn});
      chk("rgmiiRxDelayEn", {1'b0, i < 2}, {1'b0, rgmiiRxDelayEn});
      chk("linkUpEnable", 2'h1, {1'b0, linkUpEnable});
    end
    boot(2'h1, 2'h2, 2'h0, 1'b0, 1'b0, 1'b1);
    chk("powerDown", 2'h1, {1'b0, powerDown});
    wr(2'h2, 1'b0);
    chk("fifoBypass", 2'h1, {1'b0, fifoBypass});
    wr(2'h3, 1'b1);
    wr(2'h1, 1'b0);
    chk("macIfSel", 2'h1, macIfSel);
    @(posedge clk);
    {lvLo, swPowerDown} <= {2'h3, 1'b0};
    repeat (2) @(posedge clk);
    #1;
    chk("speedLevelLo", 2'h1, speedLevelLo);
    wr(2'h0, 1'b1);
    chk("macIfSel", 2'h1, macIfSel);
    @(posedge clk);
    swPowerDownSet <= 1'b1;
    @(posedge clk);
    {swPowerDownSet, swPowerDown} <= 2'h1;
    #1;
    chk("powerDown", 2'h1, {1'b0, powerDown});
    boot(2'h0, 2'h0, 2'h2, 1'b1, 1'b1, 1'b1);
    chk("macIfSel", 2'h3, macIfSel);
    chk("pwrDnLevel", 2'h2, pwrDnLevel);
    chk("linkUpEnable", 2'h0, {1'b0, linkUpEnable});
    wr(2'h2, 1'b1);
    chk("macIfSel", 2'h3, macIfSel);
    boot(2'h0, 2'h0, 2'h2, 1'b0, 1'b0, 1'b0);
    chk("powerDown", 2'h1, {1'b0, powerDown});
    wr(2'h1, 1'b1);
    chk("macIfSel", 2'h0, macIfSel);
    endOfTest();
  end
endmodule : tb_top
